// file: hdl/aps_pkg.sv
package aps_pkg;
  localparam int unsigned APS_ADDR_W  = 8;
  localparam int unsigned APS_PORT_W  = 8;
  localparam int unsigned APS_CTRL_W  = 3;
  localparam int unsigned APS_LOW_B_W = 4;

  localparam logic [7:0] APS_OFF_A_DATA   = 8'h00;
  localparam logic [7:0] APS_OFF_A_DDR    = 8'h04;
  localparam logic [7:0] APS_OFF_A_PER    = 8'h08;
  localparam logic [7:0] APS_OFF_A_PUR    = 8'h0C;
  localparam logic [7:0] APS_OFF_A_PIN    = 8'h10;
  localparam logic [7:0] APS_OFF_B_DATA   = 8'h14;
  localparam logic [7:0] APS_OFF_B_DDR    = 8'h18;
  localparam logic [7:0] APS_OFF_B_PER    = 8'h1C;
  localparam logic [7:0] APS_OFF_B_PUR    = 8'h20;
  localparam logic [7:0] APS_OFF_B_PIN    = 8'h24;
  localparam logic [7:0] APS_OFF_BUS_CTRL = 8'h28;

  localparam int unsigned APS_BUS_DRIVE_POS = 0;

  localparam logic [7:0] APS_RST_DATA    = 8'h00;
  localparam logic [7:0] APS_RST_DDR     = 8'h00;
  localparam logic [7:0] APS_RST_A_PER   = 8'hFF;
  localparam logic [7:0] APS_RST_PUR     = 8'hFF;
  localparam logic       APS_RST_DRIVE   = 1'b0;
endpackage

// file: hdl/aps_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module aps_sync3 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             mclk,    // system clock
  input  wire logic [WIDTH-1:0] asyncIn, // pin levels
  output var  logic [WIDTH-1:0] syncOut  // filtered level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // a bit changes only once stages two and three agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (s2_q[i] == s3_q[i]) begin
        syncOut[i] <= s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    s1_q <= asyncIn;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
endmodule
`default_nettype wire

// file: hdl/aps_pin_share.sv
`timescale 1ns/100ps
`default_nettype none
module aps_pin_share
  import aps_pkg::*;
(
  input  wire logic                  mclk,          // system clock, 250 MHz
  input  wire logic                  sys_rst,       // synchronous reset, active high
  input  wire logic                  psel,          // apb select
  input  wire logic                  penable,       // apb enable
  input  wire logic                  pwrite,        // apb direction
  input  wire logic [APS_ADDR_W-1:0] paddr,         // apb byte address
  input  wire logic [31:0]           pwdata,        // apb write data
  output var  logic [31:0]           prdata,        // apb read data
  output var  logic                  pready,        // apb ready
  output var  logic                  pslverr,       // apb error, unmapped
  input  wire logic [15:0]           emiAddr,       // memory address bits 23..8
  input  wire logic                  emiBusActive,  // external bus cycle running
  input  wire logic [APS_CTRL_W-1:0] emiCtrl,       // memory control strobes
  input  wire logic                  extBootStrap,  // boot strap pin
  input  wire logic                  extBusModeIn,  // bus mode pin
  input  wire logic                  flashSecure,   // flash security state
  input  wire logic [APS_PORT_W-1:0] portAIn,       // port A pad levels
  output var  logic [APS_PORT_W-1:0] portAOut,      // port A pad drive value
  output var  logic [APS_PORT_W-1:0] portAOe,       // port A output enable
  output var  logic [APS_PORT_W-1:0] portAPullEn,   // port A pull-up enable
  input  wire logic [APS_PORT_W-1:0] portBIn,       // port B pad levels
  output var  logic [APS_PORT_W-1:0] portBOut,      // port B pad drive value
  output var  logic [APS_PORT_W-1:0] portBOe,       // port B output enable
  output var  logic [APS_PORT_W-1:0] portBPullEn,   // port B pull-up enable
  output var  logic [APS_CTRL_W-1:0] ctrlOut,       // memory control pad values
  output var  logic                  ctrlOe         // memory control enable
);
  localparam int unsigned SYNC_W = 2 * APS_PORT_W + 2;

  logic [APS_PORT_W-1:0] aData_q;
  logic [APS_PORT_W-1:0] aDdr_q;
  logic [APS_PORT_W-1:0] aPer_q;
  logic [APS_PORT_W-1:0] aPur_q;
  logic [APS_PORT_W-1:0] bData_q;
  logic [APS_PORT_W-1:0] bDdr_q;
  logic [APS_PORT_W-1:0] bPer_q;
  logic [APS_PORT_W-1:0] bPur_q;
  logic                  busDrive_q;
  logic                  inReset_q;
  logic [SYNC_W-1:0]     syncVal;
  logic [APS_PORT_W-1:0] aPins;
  logic [APS_PORT_W-1:0] bPins;
  logic                  bootSync;
  logic                  modeSync;

  aps_sync3 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk   (mclk),
    .asyncIn({extBusModeIn, extBootStrap, portBIn, portAIn}),
    .syncOut(syncVal)
  );

  assign aPins    = syncVal[APS_PORT_W-1:0];
  assign bPins    = syncVal[2*APS_PORT_W-1:APS_PORT_W];
  assign bootSync = syncVal[2*APS_PORT_W];
  assign modeSync = syncVal[2*APS_PORT_W+1];

  // apb decode: one wait state, pready raised in the second access cycle
  wire accessPh = psel & penable;
  wire doneNow  = accessPh & pready;
  wire wrDone   = doneNow & pwrite;
  wire selAData = paddr == APS_OFF_A_DATA;
  wire selADdr  = paddr == APS_OFF_A_DDR;
  wire selAPer  = paddr == APS_OFF_A_PER;
  wire selAPur  = paddr == APS_OFF_A_PUR;
  wire selAPin  = paddr == APS_OFF_A_PIN;
  wire selBData = paddr == APS_OFF_B_DATA;
  wire selBDdr  = paddr == APS_OFF_B_DDR;
  wire selBPer  = paddr == APS_OFF_B_PER;
  wire selBPur  = paddr == APS_OFF_B_PUR;
  wire selBPin  = paddr == APS_OFF_B_PIN;
  wire selBus   = paddr == APS_OFF_BUS_CTRL;
  wire mapped   = selAData | selADdr | selAPer | selAPur | selAPin | selBData | selBDdr
                | selBPer | selBPur | selBPin | selBus;

  wire [APS_PORT_W-1:0] rdByte =
      ({APS_PORT_W{selAData}} & aData_q) | ({APS_PORT_W{selADdr}} & aDdr_q)
    | ({APS_PORT_W{selAPer}}  & aPer_q)  | ({APS_PORT_W{selAPur}} & aPur_q)
    | ({APS_PORT_W{selAPin}}  & aPins)   | ({APS_PORT_W{selBData}} & bData_q)
    | ({APS_PORT_W{selBDdr}}  & bDdr_q)  | ({APS_PORT_W{selBPer}} & bPer_q)
    | ({APS_PORT_W{selBPur}}  & bPur_q)  | ({APS_PORT_W{selBPin}} & bPins)
    | ({APS_PORT_W{selBus}}   & {{(APS_PORT_W-1){1'b0}}, busDrive_q});

  wire [31:0] prdata_d = {{(32-APS_PORT_W){1'b0}}, rdByte};
  wire [APS_PORT_W-1:0] wrByte = pwdata[APS_PORT_W-1:0];

  // strap decode for the low port B pins
  wire strapAddr = bootSync | (modeSync & ~flashSecure);
  wire [APS_PORT_W-1:0] bPerStrap = {{(APS_PORT_W-APS_LOW_B_W){1'b0}},
                                     {APS_LOW_B_W{strapAddr}}};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= accessPh & ~pready;
      pslverr <= accessPh & ~pready & ~mapped;
      if (accessPh & ~pready & ~pwrite) begin
        prdata <= prdata_d;
      end
    end
  end

  // data and direction registers, one direction bit per pin
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aData_q <= APS_RST_DATA;
      aDdr_q  <= APS_RST_DDR;
      bData_q <= APS_RST_DATA;
      bDdr_q  <= APS_RST_DDR;
    end else begin
      if (wrDone & selAData) begin
        aData_q <= wrByte;
      end
      if (wrDone & selADdr) begin
        aDdr_q <= wrByte;
      end
      if (wrDone & selBData) begin
        bData_q <= wrByte;
      end
      if (wrDone & selBDdr) begin
        bDdr_q <= wrByte;
      end
    end
  end

  // port A comes up in address function
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aPer_q <= APS_RST_A_PER;
    end else if (wrDone & selAPer) begin
      aPer_q <= wrByte;
    end
  end

  // a software write replaces the strap-chosen function
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bPer_q <= bPerStrap;
    end else if (wrDone & selBPer) begin
      bPer_q <= wrByte;
    end
  end

  // pull-up enable bits, bit n drives pin n
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aPur_q <= APS_RST_PUR;
      bPur_q <= APS_RST_PUR;
    end else begin
      if (wrDone & selAPur) begin
        aPur_q <= wrByte;
      end
      if (wrDone & selBPur) begin
        bPur_q <= wrByte;
      end
    end
  end

  // reset default of the drive bit is 0, software should set it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busDrive_q <= APS_RST_DRIVE;
    end else if (wrDone & selBus) begin
      busDrive_q <= pwdata[APS_BUS_DRIVE_POS];
    end
  end

  // address and control pins float when idle unless drive bit set
  wire addrDrive = busDrive_q | emiBusActive;

  // A8..A15 on port A, A16..A23 on port B pins 0..7
  wire [APS_PORT_W-1:0] aAddrBits = emiAddr[APS_PORT_W-1:0];
  wire [APS_PORT_W-1:0] bAddrBits = emiAddr[2*APS_PORT_W-1:APS_PORT_W];

  // per-pin select, set is address, clear is general purpose
  wire [APS_PORT_W-1:0] portAOut_d = (aPer_q & aAddrBits) | (~aPer_q & aData_q);
  wire [APS_PORT_W-1:0] portAOe_d  = (aPer_q & {APS_PORT_W{addrDrive}}) | (~aPer_q & aDdr_q);
  // port B general-purpose direction per pin
  wire [APS_PORT_W-1:0] portBOut_d = (bPer_q & bAddrBits) | (~bPer_q & bData_q);
  wire [APS_PORT_W-1:0] portBOe_d  = (bPer_q & {APS_PORT_W{addrDrive}}) | (~bPer_q & bDdr_q);

  always_ff @(posedge mclk) begin
    inReset_q <= sys_rst;
  end

  // in reset port B is input only with pull-ups on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      portAOut    <= {APS_PORT_W{1'b0}};
      portAOe     <= {APS_PORT_W{1'b0}};
      portAPullEn <= APS_RST_PUR;
      portBOut    <= {APS_PORT_W{1'b0}};
      portBOe     <= {APS_PORT_W{1'b0}};
      portBPullEn <= APS_RST_PUR;
      ctrlOut     <= {APS_CTRL_W{1'b1}};
      ctrlOe      <= 1'b0;
    end else begin
      portAOut    <= portAOut_d;
      portAOe     <= portAOe_d;
      portAPullEn <= aPur_q;
      portBOut    <= portBOut_d;
      portBOe     <= portBOe_d;
      portBPullEn <= bPur_q;
      ctrlOut     <= emiCtrl;
      // control strobes follow the same drive rule, but stay off in the first cycle after reset
      ctrlOe      <= addrDrive & ~inReset_q;
    end
  end
endmodule
`default_nettype wire

// file: sim/aps_chk_chk.sv
`timescale 1ns/100ps
`default_nettype none
module aps_chk
  import aps_pkg::*;
(
  input wire logic                  mclk,         // clock
  input wire logic                  sys_rst,      // reset
  input wire logic                  psel,         // apb
  input wire logic                  penable,      // apb
  input wire logic                  pwrite,       // apb
  input wire logic [APS_ADDR_W-1:0] paddr,        // apb
  input wire logic [31:0]           pwdata,       // apb
  input wire logic [31:0]           prdata,       // apb
  input wire logic                  pready,       // apb
  input wire logic                  pslverr,      // apb
  input wire logic                  emiBusActive, // bus busy
  input wire logic [APS_CTRL_W-1:0] emiCtrl,      // strobes in
  input wire logic [APS_PORT_W-1:0] portBOe,      // pad enable
  input wire logic [APS_PORT_W-1:0] portBPullEn,  // pull-ups
  input wire logic [APS_CTRL_W-1:0] ctrlOut,      // strobes out
  input wire logic                  ctrlOe        // strobe enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_rst_float: assert property (disable iff (1'b0) $past(sys_rst) |->
    portBOe == '0 && portBPullEn == 8'hFF) else $error("port B active in reset");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("wait state wrong");
  a_err_map: assert property (pready |->
    pslverr == (paddr > APS_OFF_BUS_CTRL || paddr[1:0] != 2'b00))
    else $error("error response wrong");
  a_err_zero: assert property (pslverr |-> pready && prdata == '0) else $error("error data");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == '0) else $error("upper data");
  a_pull_write: assert property (psel && penable && pready && pwrite &&
    paddr == APS_OFF_B_PUR |-> ##2 {24'h0, portBPullEn} == $past(pwdata, 2))
    else $error("pull-up write lost");
  a_ctrl_follow: assert property (!$past(sys_rst) |-> ctrlOut == $past(emiCtrl))
    else $error("strobe value late");
  // strobes driven after a bus-active cycle, from the second cycle after release
  a_ctrl_drive: assert property (!$past(sys_rst) && !$past(sys_rst, 2) &&
    $past(emiBusActive) |-> ctrlOe)
    else $error("strobes float in cycle");
endmodule
`default_nettype wire

// file: sim/aps_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module aps_pad_model
  import aps_pkg::*;
(
  input  wire logic                  mclk,   // clock
  input  wire logic [APS_PORT_W-1:0] drv,    // pad value
  input  wire logic [APS_PORT_W-1:0] oe,     // drive enable
  input  wire logic [APS_PORT_W-1:0] pullEn, // pull-up on
  output var  logic [APS_PORT_W-1:0] pad     // wire level
);
  logic [APS_PORT_W-1:0] lastDrv_q = '0;
  // undriven pins pulled, unpulled ones settle away from the last driven level
  assign pad = (oe & drv) | (~oe & pullEn) | (~oe & ~pullEn & ~lastDrv_q);
  always @(posedge mclk) begin
    if (!$isunknown(oe)) begin
      lastDrv_q <= (oe & drv) | (~oe & lastDrv_q);
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_addr_gpio_pin_sharing.sv
`timescale 1ns/100ps
`default_nettype none
module tb_addr_gpio_pin_sharing;
  import aps_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] emiAddr = 16'h3C96;
  logic        emiBusActive = 1'b0;
  logic [2:0]  emiCtrl = 3'h5;
  logic        extBootStrap = 1'b0;
  logic        extBusModeIn = 1'b0;
  logic        flashSecure = 1'b0;
  logic [7:0]  portAIn, portAOut, portAOe, portAPullEn;
  logic [7:0]  portBIn, portBOut, portBOe, portBPullEn;
  logic [2:0]  ctrlOut;
  logic        ctrlOe;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  aps_pin_share dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .emiAddr, .emiBusActive, .emiCtrl, .extBootStrap, .extBusModeIn,
    .flashSecure, .portAIn, .portAOut, .portAOe, .portAPullEn, .portBIn, .portBOut, .portBOe,
    .portBPullEn, .ctrlOut, .ctrlOe);
  aps_pad_model padA (.mclk, .drv(portAOut), .oe(portAOe), .pullEn(portAPullEn), .pad(portAIn));
  aps_pad_model padB (.mclk, .drv(portBOut), .oe(portBOe), .pullEn(portBPullEn), .pad(portBIn));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_reset();
    do_reset();
    apb(1'b0, APS_OFF_A_PER, 32'h0);
    chk("A enable", rd, 32'h000000FF);
    apb(1'b0, APS_OFF_BUS_CTRL, 32'h0);
    chk("drive bit", rd, 32'h0);
    chk("A enable out", 32'(portAOe), 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_gpio();
    apb(1'b1, APS_OFF_A_PER, 32'h0);
    apb(1'b1, APS_OFF_A_DDR, 32'h0000005A);
    apb(1'b1, APS_OFF_A_DATA, 32'h000000C3);
    apb(1'b1, APS_OFF_A_PUR, 32'h000000FE);
    apb(1'b1, APS_OFF_B_PUR, 32'h0000000F);
    repeat (6) @(posedge mclk);
    chk("A dir", 32'(portAOe), 32'h0000005A);
    chk("A out", 32'(portAOut & 8'h5A), 32'h00000042);
    chk("A pull", 32'(portAPullEn), 32'h000000FE);
    apb(1'b0, APS_OFF_A_PIN, 32'h0);
    chk("A pins", rd & 32'h000000FE, 32'h000000E6);
    $display("test gpio done");
  endtask
  task automatic t_addr();
    apb(1'b1, APS_OFF_A_PER, 32'h000000FF);
    apb(1'b1, APS_OFF_B_PER, 32'h0000001F);
    apb(1'b1, APS_OFF_B_DDR, 32'h000000F0);
    apb(1'b1, APS_OFF_B_DATA, 32'h000000A0);
    repeat (3) @(posedge mclk);
    chk("A idle", 32'(portAOe), 32'h0);
    chk("B idle", 32'(portBOe), 32'h000000E0);
    chk("ctrl idle", 32'(ctrlOe), 32'h0);
    emiBusActive <= 1'b1;
    emiCtrl <= 3'h2;
    repeat (3) @(posedge mclk);
    chk("ctrl drive", 32'(ctrlOe), 32'h1);
    chk("ctrl value", 32'(ctrlOut), 32'h2);
    chk("A addr", 32'(portAOut), 32'h00000096);
    chk("B addr", 32'(portBOut), 32'h000000BC);
    chk("B drive", 32'(portBOe), 32'h000000FF);
    emiBusActive <= 1'b0;
    apb(1'b1, APS_OFF_BUS_CTRL, 32'h00000001);
    repeat (3) @(posedge mclk);
    chk("A held", 32'(portAOe), 32'h000000FF);
    chk("ctrl held", 32'(ctrlOe), 32'h1);
    apb(1'b1, APS_OFF_B_PER, 32'h0);
    apb(1'b1, APS_OFF_B_DDR, 32'h0000000C);
    repeat (3) @(posedge mclk);
    chk("B low dir", 32'(portBOe), 32'h0000000C);
    chk("B low out", 32'(portBOut), 32'h000000A0);
    $display("test address done");
  endtask
  task automatic t_strap();
    logic [2:0] cfg [4] = '{3'b101, 3'b010, 3'b011, 3'b000};
    logic [7:0] exp [4] = '{8'h0F, 8'h0F, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      {extBootStrap, extBusModeIn, flashSecure} <= cfg[i];
      do_reset();
      apb(1'b0, APS_OFF_B_PER, 32'h0);
      chk("B strap", rd, 32'(exp[i]));
      apb(1'b1, APS_OFF_B_PER, 32'h00000005);
      apb(1'b0, APS_OFF_B_PER, 32'h0);
      chk("B override", rd, 32'h00000005);
    end
    $display("test strap done");
  endtask
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_gpio();
    t_addr();
    t_strap();
    end_of_test();
  end
endmodule
bind aps_pin_share aps_chk chk (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .emiBusActive, .emiCtrl, .portBOe, .portBPullEn, .ctrlOut,
  .ctrlOe);
`default_nettype wire
